//--- hw/arit_top.sv
// Overview of operation
// R1: periodic tick, one second or minute
// R2: tick divided from low-frequency clock
// R3: power-down keeps only comparators, timebase
// R4: separate tone, receiver, oscillator enables
// R5: four event sources raise interrupt
// R6: interrupt active level is programmable
// R7: host reads status, byte, period; sets options
// R8: other functions need system oscillator
// R9: irq register read clears pending events
// R10: oscillator bit low enters power-down
// R11: line change needs its enable bit
// R12: line change path needs no oscillator
// R13: interrupt holds while enabled source pending
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "arit_defs.svh"
module arit_top #(
  parameter int unsigned LF_PER_SEC = `ARIT_LF_PER_TB
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire arit_pkg::arit_addr_t S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire arit_pkg::arit_word_t S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire arit_pkg::arit_addr_t S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output arit_pkg::arit_word_t S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic LINE_SENSE_IN_A,
  input wire logic LINE_SENSE_IN_B,
  input wire logic TONE_ALERT_IN,
  input wire logic FSK_BYTE_VALID_IN,
  input wire arit_pkg::arit_byte_t FSK_BYTE_IN,
  input wire arit_pkg::arit_ring_t RING_PERIOD_IN,
  input wire logic LF_TICK_IN,
  output logic IRQ_OUT,
  output logic HF_OSC_EN_OUT,
  output logic ADC_EN_OUT,
  output logic TONE_DET_EN_OUT,
  output logic FSK_RX_EN_OUT
);
  import arit_pkg::*;

  // ***************************************
  // state
  // ***************************************
  arit_byte_t mode1_r;
  arit_byte_t mode2_r;
  arit_pend_t pend_r;
  arit_pend_t pend_nxt;
  arit_byte_t fsk_data_r;
  arit_ring_t ring_r;
  logic sense_a_r;
  logic sense_b_r;
  logic irq_r;
  logic aw_hold_r;
  arit_addr_t aw_addr_r;
  logic w_hold_r;
  arit_byte_t w_data_r;
  logic w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  arit_word_t rdata_r;
  logic [1:0] rresp_r;

  arit_tb_if tbi ();

  // ***************************************
  // mode decode
  // ***************************************
  // R10: oscillator enable
  // clearing this bit stops the system clock and the converter
  wire osc_en = mode2_r[`ARIT_M2_OSC_EN];
  // R4: separate enables
  // a detector without a running oscillator counts as switched off
  wire tone_en = mode2_r[`ARIT_M2_TONE_EN] && osc_en;
  wire fsk_en = mode2_r[`ARIT_M2_FSK_EN] && osc_en;
  wire sense_en = mode1_r[`ARIT_M1_SENSE_EN];
  wire tb_en = mode1_r[`ARIT_M1_TB_EN];
  wire irq_high = mode1_r[`ARIT_M1_IRQ_HIGH];

  // R3: power-down outputs
  assign HF_OSC_EN_OUT = osc_en;
  assign ADC_EN_OUT = osc_en;
  assign TONE_DET_EN_OUT = tone_en;
  assign FSK_RX_EN_OUT = fsk_en;

  // ***************************************
  // timebase
  // ***************************************
  assign tbi.lf_tick = LF_TICK_IN;
  assign tbi.enable = tb_en;
  assign tbi.minute = mode1_r[`ARIT_M1_TB_MIN];

  // R2: low clock divider
  arit_timebase #(
    .LF_PER_SEC(LF_PER_SEC)
  ) u_timebase (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .tb(tbi.tb)
  );

  // ***************************************
  // event sources
  // ***************************************
  // R12: line change path
  // compares against last sample, independent of the oscillator bit
  wire sense_chg = (LINE_SENSE_IN_A ^ sense_a_r) || (LINE_SENSE_IN_B ^ sense_b_r);
  // R11: gated by enable
  wire ev_sense = sense_chg && sense_en;
  // R8: needs system oscillator
  wire ev_fsk = FSK_BYTE_VALID_IN && fsk_en;
  wire ev_tone = TONE_ALERT_IN && tone_en;
  wire ev_tb = tbi.tick;

  // R5: four sources
  wire [3:0] ev_set = {ev_tb, ev_tone, ev_fsk, ev_sense};
  wire [3:0] src_en = {tb_en, tone_en, fsk_en, sense_en};

  // ***************************************
  // bus decode
  // ***************************************
  wire aw_fire = S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT;
  wire w_fire = S_AXI_WVALID_IN && S_AXI_WREADY_OUT;
  wire ar_fire = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
  wire wr_do = aw_hold_r && w_hold_r && !bvalid_r;
  wire wr_m1 = wr_do && w_strb_r && (aw_addr_r == `ARIT_OFF_MODE1);
  wire wr_m2 = wr_do && w_strb_r && (aw_addr_r == `ARIT_OFF_MODE2);
  wire wr_hit = (aw_addr_r == `ARIT_OFF_MODE1) || (aw_addr_r == `ARIT_OFF_MODE2);
  // R9: read clears
  wire rd_clr = ar_fire && (S_AXI_ARADDR_IN == `ARIT_OFF_IRQ);

  // R7: host reads status, byte, period
  arit_word_t rd_mux;
  logic rd_hit;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (S_AXI_ARADDR_IN)
      `ARIT_OFF_MODE1: rd_mux = {24'h00_0000, mode1_r};
      `ARIT_OFF_MODE2: rd_mux = {24'h00_0000, mode2_r};
      `ARIT_OFF_STATUS: begin
        rd_mux[`ARIT_ST_SENSE_A] = LINE_SENSE_IN_A;
        rd_mux[`ARIT_ST_SENSE_B] = LINE_SENSE_IN_B;
        rd_mux[3:0] = pend_r;
      end
      `ARIT_OFF_IRQ: rd_mux = {28'h000_0000, pend_r};
      `ARIT_OFF_FSK: rd_mux = {24'h00_0000, fsk_data_r};
      `ARIT_OFF_RING: rd_mux = {16'h0000, ring_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // one write and one read in flight; holds stall the channels
  assign S_AXI_AWREADY_OUT = !aw_hold_r && !bvalid_r;
  assign S_AXI_WREADY_OUT = !w_hold_r && !bvalid_r;
  assign S_AXI_ARREADY_OUT = !rvalid_r;
  assign S_AXI_BVALID_OUT = bvalid_r;
  assign S_AXI_BRESP_OUT = bresp_r;
  assign S_AXI_RVALID_OUT = rvalid_r;
  assign S_AXI_RDATA_OUT = rdata_r;
  assign S_AXI_RRESP_OUT = rresp_r;

  // ***************************************
  // pending and interrupt
  // ***************************************
  // R9: set wins over clear
  // an event in the clearing read's cycle stays pending
  assign pend_nxt = (pend_r & ~{4{rd_clr}}) | ev_set;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      pend_r <= 4'h0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // R13: level while pending
  // disabling a source also hides its stale pending bit
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(pend_nxt & src_en);
    end
  end

  // R6: programmable level
  assign IRQ_OUT = irq_high ? irq_r : !irq_r;

  // ***************************************
  // line comparators and data capture
  // ***************************************
  // R12: line change detect
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      sense_a_r <= 1'b0;
      sense_b_r <= 1'b0;
    end else begin
      sense_a_r <= LINE_SENSE_IN_A;
      sense_b_r <= LINE_SENSE_IN_B;
    end
  end

  // R8: capture needs oscillator
  // byte and period freeze in power-down, keeping the last values readable
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      fsk_data_r <= 8'h00;
    end else if (ev_fsk) begin
      fsk_data_r <= FSK_BYTE_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      ring_r <= 16'h0000;
    end else if (osc_en) begin
      ring_r <= RING_PERIOD_IN;
    end
  end

  // ***************************************
  // mode registers
  // ***************************************
  // R7: host sets options
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      mode1_r <= `ARIT_RST_MODE1;
    end else if (wr_m1) begin
      mode1_r <= w_data_r;
    end
  end

  // R10: power-down entry
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      mode2_r <= `ARIT_RST_MODE2;
    end else if (wr_m2) begin
      mode2_r <= w_data_r;
    end
  end

  // ***************************************
  // bus write channel
  // ***************************************
  // address and data may arrive in either order
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
    end else if (aw_fire) begin
      aw_hold_r <= 1'b1;
      aw_addr_r <= S_AXI_AWADDR_IN;
    end else if (wr_do) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      w_hold_r <= 1'b0;
      w_data_r <= 8'h00;
      w_strb_r <= 1'b0;
    end else if (w_fire) begin
      w_hold_r <= 1'b1;
      w_data_r <= S_AXI_WDATA_IN[7:0];
      w_strb_r <= S_AXI_WSTRB_IN[0];
    end else if (wr_do) begin
      w_hold_r <= 1'b0;
    end
  end

  // response after both halves; any address but the two mode registers answers with an error
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      bvalid_r <= 1'b0;
      bresp_r <= `ARIT_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? `ARIT_RESP_OKAY : `ARIT_RESP_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      bvalid_r <= 1'b0;
    end
  end

  // ***************************************
  // bus read channel
  // ***************************************
  // data sampled at acceptance so it matches the clearing read
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `ARIT_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? `ARIT_RESP_OKAY : `ARIT_RESP_SLVERR;
    end else if (S_AXI_RREADY_IN) begin
      rvalid_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- pkg/arit_defs.svh
`ifndef ARIT_DEFS_SVH
`define ARIT_DEFS_SVH

// ***************************************
// register byte offsets
// ***************************************
`define ARIT_OFF_MODE1 8'h00
`define ARIT_OFF_MODE2 8'h04
`define ARIT_OFF_STATUS 8'h08
`define ARIT_OFF_IRQ 8'h0C
`define ARIT_OFF_FSK 8'h10
`define ARIT_OFF_RING 8'h14

// ***************************************
// field positions
// ***************************************
// first mode register
`define ARIT_M1_TB_EN 0
`define ARIT_M1_TB_MIN 1
`define ARIT_M1_IRQ_HIGH 2
`define ARIT_M1_SENSE_EN 4
// second mode register
`define ARIT_M2_FSK_EN 5
`define ARIT_M2_TONE_EN 6
`define ARIT_M2_OSC_EN 7
// pending bits in the irq register
`define ARIT_P_SENSE 0
`define ARIT_P_FSK 1
`define ARIT_P_TONE 2
`define ARIT_P_TB 3
// line comparator levels in the status register
`define ARIT_ST_SENSE_A 7
`define ARIT_ST_SENSE_B 6

// ***************************************
// reset values
// ***************************************
`define ARIT_RST_MODE1 8'h00
`define ARIT_RST_MODE2 8'h80

// ***************************************
// timebase
// ***************************************
`define ARIT_LF_HZ 32768
`define ARIT_TB_PERIOD_S 1
`define ARIT_LF_PER_TB (`ARIT_LF_HZ * `ARIT_TB_PERIOD_S)
`define ARIT_SEC_PER_MIN 60

// ***************************************
// bus answers
// ***************************************
`define ARIT_RESP_OKAY 2'h0
`define ARIT_RESP_SLVERR 2'h2

`endif

//--- pkg/arit_pkg.sv
`default_nettype none
package arit_pkg;
  typedef logic [7:0] arit_byte_t;
  typedef logic [7:0] arit_addr_t;
  typedef logic [31:0] arit_word_t;
  typedef logic [15:0] arit_ring_t;
  typedef logic [3:0] arit_pend_t;
endpackage
`default_nettype wire

//--- pkg/arit_tb_if.sv
`timescale 1ns/1ps
`default_nettype none
// control and tick between the core and its timebase
interface arit_tb_if;
  logic lf_tick;
  logic enable;
  logic minute;
  logic tick;
  modport tb (input lf_tick, input enable, input minute, output tick);
  modport ctl (output lf_tick, output enable, output minute, input tick);
endinterface
`default_nettype wire

//--- hw/arit_timebase.sv
`timescale 1ns/1ps
`default_nettype none
`include "arit_defs.svh"
module arit_timebase #(
  parameter int unsigned LF_PER_SEC = `ARIT_LF_PER_TB
) (
  input wire logic clk_in,
  input wire logic rst_in,
  arit_tb_if.tb tb
);
  import arit_pkg::*;

  logic [15:0] sub_r;
  logic [5:0] sec_r;
  logic tick_r;
  wire sub_wrap = tb.lf_tick && (sub_r == 16'(LF_PER_SEC - 1));
  wire sec_last = sec_r == 6'(`ARIT_SEC_PER_MIN - 1);
  wire tick_nxt = sub_wrap && (!tb.minute || sec_last);

  assign tb.tick = tick_r;

  // R2: divide low clock
  // counts only low-frequency ticks so the period holds in power-down
  always_ff @(posedge clk_in) begin
    if (rst_in || !tb.enable) begin
      sub_r <= 16'h0000;
    end else if (sub_wrap) begin
      sub_r <= 16'h0000;
    end else if (tb.lf_tick) begin
      sub_r <= sub_r + 16'h0001;
    end
  end

  // R1: second or minute
  // seconds counter only matters in minute mode
  always_ff @(posedge clk_in) begin
    if (rst_in || !tb.enable) begin
      sec_r <= 6'h00;
    end else if (sub_wrap) begin
      sec_r <= sec_last ? 6'h00 : sec_r + 6'h01;
    end
  end

  // one-cycle tick per period
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt && tb.enable;
    end
  end
endmodule
`default_nettype wire

//--- test/arit_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks
// ****
module arit_chk #(
  parameter int unsigned LF_PER_SEC = 4
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic S_AXI_AWREADY_OUT,
  input wire logic S_AXI_WREADY_OUT,
  input wire logic [1:0] S_AXI_BRESP_OUT,
  input wire logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic S_AXI_ARVALID_IN,
  input wire logic S_AXI_ARREADY_OUT,
  input wire arit_pkg::arit_word_t S_AXI_RDATA_OUT,
  input wire logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN,
  input wire logic HF_OSC_EN_OUT,
  input wire logic ADC_EN_OUT,
  input wire logic TONE_DET_EN_OUT,
  input wire logic FSK_RX_EN_OUT
);
  import arit_pkg::*;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);
  AST_B_HOLD: assert property (
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
    else $error("read answer dropped");
  AST_R_NEXT: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
    else $error("read not answered");
  AST_AR_BLOCK: assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
    else $error("read taken while busy");
  AST_W_BLOCK: assert property (S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
    else $error("write taken while busy");
  AST_ADC_OSC: assert property (ADC_EN_OUT == HF_OSC_EN_OUT)
    else $error("adc and oscillator differ");
  AST_PD_GATE: assert property (!HF_OSC_EN_OUT |-> !TONE_DET_EN_OUT && !FSK_RX_EN_OUT)
    else $error("detector alive in power-down");
  AST_EN_WRITE: assert property (
    $changed({HF_OSC_EN_OUT, TONE_DET_EN_OUT, FSK_RX_EN_OUT}) |-> $rose(S_AXI_BVALID_OUT))
    else $error("enable changed without write");
  cover property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN);
  cover property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN);
  cover property ($fell(HF_OSC_EN_OUT));
endmodule
bind arit_top arit_chk #(.LF_PER_SEC(LF_PER_SEC)) chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .S_AXI_AWREADY_OUT(S_AXI_AWREADY_OUT), .S_AXI_WREADY_OUT(S_AXI_WREADY_OUT),
  .S_AXI_BRESP_OUT(S_AXI_BRESP_OUT), .S_AXI_BVALID_OUT(S_AXI_BVALID_OUT), .S_AXI_BREADY_IN(S_AXI_BREADY_IN),
  .S_AXI_ARVALID_IN(S_AXI_ARVALID_IN), .S_AXI_ARREADY_OUT(S_AXI_ARREADY_OUT),
  .S_AXI_RDATA_OUT(S_AXI_RDATA_OUT), .S_AXI_RVALID_OUT(S_AXI_RVALID_OUT), .S_AXI_RREADY_IN(S_AXI_RREADY_IN),
  .HF_OSC_EN_OUT(HF_OSC_EN_OUT), .ADC_EN_OUT(ADC_EN_OUT), .TONE_DET_EN_OUT(TONE_DET_EN_OUT),
  .FSK_RX_EN_OUT(FSK_RX_EN_OUT));
`default_nettype wire

//--- test/arit_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// register bus host
// ****
module arit_host (
  input wire logic clk_in,
  output arit_pkg::arit_addr_t aw_a_out,
  output logic aw_v_out,
  input wire logic aw_r_in,
  output arit_pkg::arit_word_t w_d_out,
  output logic [3:0] w_s_out,
  output logic w_v_out,
  input wire logic w_r_in,
  input wire logic b_v_in,
  output logic b_r_out,
  output arit_pkg::arit_addr_t ar_a_out,
  output logic ar_v_out,
  input wire logic ar_r_in,
  input wire logic r_v_in,
  output logic r_r_out
);
  import arit_pkg::*;
  // idle bus; all lanes on, only lane 0 matters
  initial begin
    {aw_v_out, w_v_out, b_r_out, ar_v_out, r_r_out} = 5'h00;
    {aw_a_out, ar_a_out, w_d_out} = 48'h0;
    w_s_out = 4'hF;
  end
  task automatic wr(input arit_addr_t a, input arit_byte_t d, input logic [3:0] s, output bit ok);
    int n;
    ok = 0;
    @(posedge clk_in);
    aw_a_out <= a;
    w_d_out <= {24'h000000, d};
    w_s_out <= s;
    {aw_v_out, w_v_out, b_r_out} <= 3'h7;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clk_in);
      if (aw_v_out && aw_r_in) aw_v_out <= 1'h0;
      if (w_v_out && w_r_in) w_v_out <= 1'h0;
      if (b_v_in) b_r_out <= 1'h0;
      ok = b_v_in;
    end
  endtask
  task automatic rd(input arit_addr_t a, output bit ok);
    int n;
    ok = 0;
    @(posedge clk_in);
    ar_a_out <= a;
    {ar_v_out, r_r_out} <= 2'h3;
    for (n = 0; n < 64 && !ok; n++) begin
      @(posedge clk_in);
      if (ar_v_out && ar_r_in) ar_v_out <= 1'h0;
      if (r_v_in) r_r_out <= 1'h0;
      ok = r_v_in;
    end
  endtask
endmodule
`default_nettype wire

//--- test/arit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module arit_tb;
  import arit_pkg::*;
  localparam int unsigned LF = 4;
  localparam logic [1:0] rok = 2'h0;
  logic clk = 1'h0, rst = 1'h1, lb = 1'h0;
  logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r, irq, hf, adc, ton, fsk;
  logic [3:0] w_s, src = 4'h0, strb = 4'hF;
  logic [1:0] b_rs, r_rs;
  arit_addr_t aw_a, ar_a;
  arit_word_t w_d, r_d;
  arit_byte_t fb = 8'h00, d;
  arit_ring_t ring = 16'h0000;
  logic [33:0] q[$];
  logic [33:0] e;
  int fail_count = 0, comparisons = 0, seed = 27, i;
  always #50 clk = ~clk;
  arit_top #(.LF_PER_SEC(LF)) uut (.CLK_IN(clk), .RST_IN(rst), .S_AXI_AWADDR_IN(aw_a),
    .S_AXI_AWVALID_IN(aw_v), .S_AXI_AWREADY_OUT(aw_r), .S_AXI_WDATA_IN(w_d), .S_AXI_WSTRB_IN(w_s),
    .S_AXI_WVALID_IN(w_v), .S_AXI_WREADY_OUT(w_r), .S_AXI_BRESP_OUT(b_rs), .S_AXI_BVALID_OUT(b_v),
    .S_AXI_BREADY_IN(b_r), .S_AXI_ARADDR_IN(ar_a), .S_AXI_ARVALID_IN(ar_v), .S_AXI_ARREADY_OUT(ar_r),
    .S_AXI_RDATA_OUT(r_d), .S_AXI_RRESP_OUT(r_rs), .S_AXI_RVALID_OUT(r_v), .S_AXI_RREADY_IN(r_r),
    .LINE_SENSE_IN_A(src[0]), .LINE_SENSE_IN_B(lb), .TONE_ALERT_IN(src[2]), .FSK_BYTE_VALID_IN(src[1]),
    .FSK_BYTE_IN(fb), .RING_PERIOD_IN(ring), .LF_TICK_IN(src[3]), .IRQ_OUT(irq), .HF_OSC_EN_OUT(hf),
    .ADC_EN_OUT(adc), .TONE_DET_EN_OUT(ton), .FSK_RX_EN_OUT(fsk));
  arit_host host (.clk_in(clk), .aw_a_out(aw_a), .aw_v_out(aw_v), .aw_r_in(aw_r), .w_d_out(w_d),
    .w_s_out(w_s), .w_v_out(w_v), .w_r_in(w_r), .b_v_in(b_v), .b_r_out(b_r), .ar_a_out(ar_a),
    .ar_v_out(ar_v), .ar_r_in(ar_r), .r_v_in(r_v), .r_r_out(r_r));
  // oldest note against each bus answer
  always @(posedge clk) begin
    if ((b_v && b_r) || (r_v && r_r)) begin
      e = q.pop_front();
      `CHK(b_v ? {b_rs, 32'h00000000} : {r_rs, r_d}, e)
    end
  end
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic hang();
    fail_count++;
    complete_run();
  endtask
  task automatic wr(input arit_addr_t a, input arit_byte_t v, input logic [1:0] r);
    bit ok;
    q.push_back({r, 32'h00000000});
    host.wr(a, v, strb, ok);
    if (!ok) hang();
    #1;
  endtask
  task automatic rd(input arit_addr_t a, input arit_word_t v, input logic [1:0] r);
    bit ok;
    q.push_back({r, v});
    host.rd(a, ok);
    if (!ok) hang();
    #1;
  endtask
  // one-cycle pulse on one event source, then let it settle
  task automatic ev(input int k);
    @(posedge clk);
    src[k] <= 1'h1;
    @(posedge clk);
    src[k] <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    rd(8'h00, 32'h00000000, rok);
    rd(8'h04, 32'h00000080, rok);
    `CHK({hf, adc, ton, fsk, irq}, 5'h19)
    rd(8'h18, 32'h00000000, 2'h2);
    wr(8'h08, 8'hFF, 2'h2);
    // lane 0 off: write answered but ignored
    strb = 4'hE;
    wr(8'h00, 8'h14, rok);
    strb = 4'hF;
    rd(8'h00, 32'h00000000, rok);
    // random enable mixes, power-down among them
    for (i = 0; i < 6; i++) begin
      d = 8'($random(seed)) & 8'hE0;
      wr(8'h04, d, rok);
      rd(8'h04, {24'h000000, d}, rok);
      `CHK({hf, adc, ton, fsk}, {d[7], d[7], d[7] & d[6], d[7] & d[5]})
    end
    wr(8'h04, 8'hE0, rok);
    wr(8'h00, 8'h14, rok);
    @(posedge clk);
    fb <= 8'($random(seed));
    ring <= 16'($random(seed));
    for (i = 0; i < 3; i++) begin
      ev(i);
      `CHK(irq, 1'h1)
      rd(8'h0C, 32'h00000001 << i, rok);
      `CHK(irq, 1'h0)
    end
    rd(8'h10, {24'h000000, fb}, rok);
    rd(8'h14, {16'h0000, ring}, rok);
    wr(8'h04, 8'h80, rok);
    rd(8'h0C, 32'h00000000, rok);
    wr(8'h04, 8'h00, rok);
    ev(2);
    ev(1);
    `CHK(irq, 1'h0)
    ev(0);
    `CHK(irq, 1'h1)
    rd(8'h0C, 32'h00000001, rok);
    // period capture stops with the oscillator
    @(posedge clk);
    ring <= ~ring;
    @(posedge clk);
    rd(8'h14, {16'h0000, ~ring}, rok);
    wr(8'h00, 8'h04, rok);
    @(posedge clk);
    lb <= 1'h1;
    rd(8'h08, 32'h00000040, rok);
    wr(8'h00, 8'h01, rok);
    repeat (LF - 1) ev(3);
    `CHK(irq, 1'h1)
    ev(3);
    `CHK(irq, 1'h0)
    rd(8'h0C, 32'h00000008, rok);
    wr(8'h00, 8'h04, rok);
    wr(8'h00, 8'h07, rok);
    repeat (60 * LF - 1) ev(3);
    `CHK(irq, 1'h0)
    ev(3);
    `CHK(irq, 1'h1)
    rd(8'h0C, 32'h00000008, rok);
    complete_run();
  end
endmodule
`default_nettype wire
